/* File: shared/debounce_pkg.sv */
// Constants shared by the sampling switch debouncer
package debounce_pkg;

  // Channel count and bus widths
  localparam int unsigned CH_COUNT   = 4;
  localparam int unsigned COUNT_W    = 8;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL      = 8'h00;
  localparam logic [7:0] OFS_HALF_PERIOD  = 8'h04;
  localparam logic [7:0] OFS_LEVEL_STATUS = 8'h08;
  localparam logic [7:0] OFS_EDGE_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_EVENT_COUNT  = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_INVERT_BIT = 1;
  localparam logic        CTRL_ENABLE_RST = 1'b1;
  localparam logic        CTRL_INVERT_RST = 1'b0;

  // Edge status layout: rising edges low, falling edges above
  localparam int unsigned EDGE_RISE_LSB = 0;
  localparam int unsigned EDGE_FALL_LSB = CH_COUNT;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sample timing: 100 samples per second on a 100 MHz clock
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned SAMPLE_PERIOD_MS = 10;
  localparam int unsigned NS_PER_MS        = 1000000;
  localparam logic [31:0] HALF_PERIOD_CYCLES =
    32'((SAMPLE_PERIOD_MS * NS_PER_MS) / CLK_PERIOD_NS / 2);

endpackage : debounce_pkg

/* File: src/switch_debouncer.sv */
// Sampling switch debouncer with AXI4-Lite status and control registers
//
// Summary of operation
// - Sample only on periodic tick, never raw edges
// - Shift current into previous, compare on tick
// - Any difference: report edge, bump 8-bit count
// - First sample loads both, reports nothing
// - Level zero means pressed, one released; with the invert bit set the level reads one while pressed
// - Sample only on sample clock rising edge
// - Sample clock from toggle divider at double rate
// - Debounced outputs reset to zero
// - Readable status tells rising from falling edge
// - Edge status bits sticky, cleared by read
// - Edge and level outputs usable by logic
// - Channel count parameter, identical independent channels
// - Sampled levels readable in a status register
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps

module switch_debouncer #(
  parameter logic [31:0] HALF_PERIOD = debounce_pkg::HALF_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire  logic                                clk,
  input  wire  logic                                arst_n,
  // Switch pins, pulled up, low while pressed
  input  wire  logic [debounce_pkg::CH_COUNT-1:0]   switch_input,
  // AXI4-Lite write address
  input  wire  logic [debounce_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire  logic [2:0]                          s_axi_awprot,
  input  wire  logic                                s_axi_awvalid,
  output logic                                      s_axi_awready,
  // AXI4-Lite write data
  input  wire  logic [debounce_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire  logic [3:0]                          s_axi_wstrb,
  input  wire  logic                                s_axi_wvalid,
  output logic                                      s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire  logic                                s_axi_bready,
  // AXI4-Lite read address
  input  wire  logic [debounce_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire  logic [2:0]                          s_axi_arprot,
  input  wire  logic                                s_axi_arvalid,
  output logic                                      s_axi_arready,
  // AXI4-Lite read data
  output logic [debounce_pkg::DATA_W-1:0]           s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire  logic                                s_axi_rready,
  // Debounced levels and event pulses for other logic or DMA
  output logic [debounce_pkg::CH_COUNT-1:0]         debounced_level,
  output logic [debounce_pkg::CH_COUNT-1:0]         rise_pulse,
  output logic [debounce_pkg::CH_COUNT-1:0]         fall_pulse,
  output logic [debounce_pkg::CH_COUNT-1:0]         either_pulse,
  output logic                                      filtered_event_irq,
  output logic                                      sample_tick_irq
);

  localparam int unsigned CH = debounce_pkg::CH_COUNT;
  localparam int unsigned CW = debounce_pkg::COUNT_W;

  // Whole module state
  typedef struct packed {
    logic [CH-1:0]    sync1;
    logic [CH-1:0]    sync2;
    logic [1:0]       warm;
    logic             enable;
    logic             invert;
    logic [31:0]      half_period;
    logic [31:0]      prescale;
    logic             toggle_divider;
    logic             primed;
    logic [CH-1:0]    cur;
    logic [CH-1:0]    prev;
    logic [CH-1:0]    rise_sticky;
    logic [CH-1:0]    fall_sticky;
    logic [CH*CW-1:0] counts;
    logic [CH-1:0]    rise_p;
    logic [CH-1:0]    fall_p;
    logic [CH-1:0]    either_p;
    logic             event_p;
    logic             tick_p;
    logic             awready;
    logic             wready;
    logic             aw_held;
    logic             w_held;
    logic [7:0]       waddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
  } state_s;

  state_s s;
  state_s next_s;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // Next-state logic for sampling, status and bus slave
  always_comb begin
    logic [CH-1:0] sample;
    logic [CH-1:0] rise_now;
    logic [CH-1:0] fall_now;
    logic          tick;
    logic          rd_take;
    logic          clr_edges;
    logic [31:0]   ctrl_word;
    logic [31:0]   merged;
    logic [31:0]   reload;
    sample    = '0;
    rise_now  = '0;
    fall_now  = '0;
    tick      = 1'b0;
    rd_take   = 1'b0;
    clr_edges = 1'b0;
    ctrl_word = '0;
    merged    = '0;
    reload    = '0;
    next_s    = s;

    // Synchronizer; only the second stage is read below
    next_s.sync1 = switch_input;
    next_s.sync2 = s.sync1;
    sample = s.sync2 ^ {CH{s.invert}};
    // Second stage shows the pin only after two edges out of reset
    if (s.warm != 2'h2) begin
      next_s.warm = s.warm + 2'h1;
    end

    // Half-period prescaler drives the toggle divider
    reload = (s.half_period == 32'h0) ? 32'h0 : s.half_period - 32'h1;
    if (!s.enable) begin
      next_s.prescale       = reload;
      next_s.toggle_divider = 1'b0;
    end else if (s.prescale == 32'h0) begin
      next_s.prescale       = reload;
      next_s.toggle_divider = ~s.toggle_divider;
      tick = ~s.toggle_divider;
    end else begin
      next_s.prescale = s.prescale - 32'h1;
    end

    // Samples taken on the tick only, never on raw pin edges
    next_s.rise_p  = '0;
    next_s.fall_p  = '0;
    next_s.either_p = '0;
    next_s.event_p = 1'b0;
    next_s.tick_p  = tick;
    if (tick) begin
      if (!s.primed) begin
        // Priming on reset data would fake an edge at the next tick
        if (s.warm == 2'h2) begin
          next_s.primed = 1'b1;
          next_s.cur    = sample;
          next_s.prev   = sample;
        end
      end else begin
        next_s.prev = s.cur;
        next_s.cur  = sample;
        // With invert clear, rising means released, falling means pressed
        rise_now = sample & ~s.cur;
        fall_now = ~sample & s.cur;
      end
    end

    // Per-channel counters, each wrapping at eight bits
    for (int c = 0; c < CH; c++) begin
      if (rise_now[c] | fall_now[c]) begin
        next_s.counts[c*CW +: CW] = s.counts[c*CW +: CW] + 8'h01;
      end
    end
    next_s.rise_p   = rise_now;
    next_s.fall_p   = fall_now;
    next_s.either_p = rise_now | fall_now;
    next_s.event_p  = |(rise_now | fall_now);

    // Read channel: one outstanding read
    rd_take = s.arready & s_axi_arvalid;
    if (s.rvalid & s_axi_rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
    if (rd_take) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rresp   = debounce_pkg::RESP_OKAY;
      ctrl_word = '0;
      ctrl_word[debounce_pkg::CTRL_ENABLE_BIT] = s.enable;
      ctrl_word[debounce_pkg::CTRL_INVERT_BIT] = s.invert;
      unique case ({s_axi_araddr[7:2], 2'b00})
        debounce_pkg::OFS_CONTROL:      next_s.rdata = ctrl_word;
        debounce_pkg::OFS_HALF_PERIOD:  next_s.rdata = s.half_period;
        debounce_pkg::OFS_LEVEL_STATUS: next_s.rdata = 32'(s.cur);
        debounce_pkg::OFS_EDGE_STATUS: begin
          next_s.rdata = 32'({s.fall_sticky, s.rise_sticky});
          clr_edges = 1'b1;
        end
        debounce_pkg::OFS_EVENT_COUNT:  next_s.rdata = 32'(s.counts);
        default: begin
          next_s.rdata = 32'h0;
          next_s.rresp = debounce_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Sticky edge flags: a new edge outranks the read that clears
    next_s.rise_sticky = (clr_edges ? '0 : s.rise_sticky) | rise_now;
    next_s.fall_sticky = (clr_edges ? '0 : s.fall_sticky) | fall_now;

    // Write address and data taken in either order
    if (s.awready & s_axi_awvalid) begin
      next_s.aw_held = 1'b1;
      next_s.awready = 1'b0;
      next_s.waddr   = s_axi_awaddr;
    end
    if (s.wready & s_axi_wvalid) begin
      next_s.w_held = 1'b1;
      next_s.wready = 1'b0;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    if (s.bvalid & s_axi_bready) begin
      next_s.bvalid  = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
    end

    // Commit once both halves are in, answering the next cycle
    if (next_s.aw_held & next_s.w_held & ~s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = debounce_pkg::RESP_OKAY;
      unique case ({next_s.waddr[7:2], 2'b00})
        debounce_pkg::OFS_CONTROL: begin
          if (next_s.wstrb[0]) begin
            next_s.enable = next_s.wdata[debounce_pkg::CTRL_ENABLE_BIT];
            next_s.invert = next_s.wdata[debounce_pkg::CTRL_INVERT_BIT];
          end
        end
        debounce_pkg::OFS_HALF_PERIOD: begin
          merged = merge_bytes(s.half_period, next_s.wdata, next_s.wstrb);
          next_s.half_period = merged;
        end
        // Status words are read-only; writes change nothing
        debounce_pkg::OFS_LEVEL_STATUS,
        debounce_pkg::OFS_EDGE_STATUS,
        debounce_pkg::OFS_EVENT_COUNT: next_s.bresp = debounce_pkg::RESP_OKAY;
        default: next_s.bresp = debounce_pkg::RESP_SLVERR;
      endcase
    end
  end

  // State register; every field resets to a constant
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s                <= '0;
      s.enable         <= debounce_pkg::CTRL_ENABLE_RST;
      s.invert         <= debounce_pkg::CTRL_INVERT_RST;
      s.half_period    <= HALF_PERIOD;
      s.awready        <= 1'b1;
      s.wready         <= 1'b1;
      s.arready        <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state flip-flops
  assign debounced_level    = s.cur;
  assign rise_pulse         = s.rise_p;
  assign fall_pulse         = s.fall_p;
  assign either_pulse       = s.either_p;
  assign filtered_event_irq = s.event_p;
  assign sample_tick_irq    = s.tick_p;
  assign s_axi_awready      = s.awready;
  assign s_axi_wready       = s.wready;
  assign s_axi_bresp        = s.bresp;
  assign s_axi_bvalid       = s.bvalid;
  assign s_axi_arready      = s.arready;
  assign s_axi_rdata        = s.rdata;
  assign s_axi_rresp        = s.rresp;
  assign s_axi_rvalid       = s.rvalid;

endmodule : switch_debouncer

/* File: tb/switch_debouncer_chk.sv */
// Port assertions for the sampling switch debouncer
`timescale 1ns/10ps
module switch_debouncer_chk #(
  parameter logic [31:0] HALF_PERIOD = 32'h4
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // Register bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Debounced outputs
  input wire logic [3:0]  debounced_level,
  input wire logic [3:0]  rise_pulse,
  input wire logic [3:0]  fall_pulse,
  input wire logic [3:0]  either_pulse,
  input wire logic        filtered_event_irq,
  input wire logic        sample_tick_irq
);
  logic [15:0] gap;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Cycles since last tick, saturating so a long pause cannot wrap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) gap <= 16'hffff;
    else if (sample_tick_irq) gap <= 16'h1;
    else if (gap != 16'hffff) gap <= gap + 16'h1;
  end
  pulse_sum_a: assert property (either_pulse == (rise_pulse | fall_pulse))
    else $error("either pulse differs from rise or fall");
  irq_merge_a: assert property (filtered_event_irq == (|either_pulse))
    else $error("event irq differs from pulses");
  pulse_width_a: assert property ((|either_pulse) |=>
    (either_pulse & $past(either_pulse)) == 4'h0)
    else $error("edge pulse longer than one cycle");
  pulse_tick_a: assert property ((|either_pulse) |-> sample_tick_irq)
    else $error("edge pulse without a tick");
  level_tick_a: assert property (!$stable(debounced_level) |-> sample_tick_irq)
    else $error("level moved between ticks");
  rise_dir_a: assert property ((|rise_pulse) |->
    ((rise_pulse & ~debounced_level) | (rise_pulse & $past(debounced_level))) == 4'h0)
    else $error("rise pulse without low to high");
  fall_dir_a: assert property ((|fall_pulse) |->
    ((fall_pulse & debounced_level) | (fall_pulse & ~$past(debounced_level))) == 4'h0)
    else $error("fall pulse without high to low");
  tick_gap_a: assert property (sample_tick_irq |-> 32'(gap) >= 2 * HALF_PERIOD)
    else $error("ticks closer than one sample period");
  write_ans_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid)
    else $error("no write response");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read response");
endmodule : switch_debouncer_chk
bind switch_debouncer switch_debouncer_chk #(.HALF_PERIOD(HALF_PERIOD)) u_chk (.clk, .arst_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .debounced_level, .rise_pulse,
  .fall_pulse, .either_pulse, .filtered_event_irq, .sample_tick_irq);

/* File: tb/switch_model.sv */
// Bouncing push-buttons with pull-ups
`timescale 1ns/10ps
module switch_model (
  // Clock and wanted contact state, 0 pressed
  input  wire logic       clk,
  input  wire logic [3:0] target,
  // Pin levels
  output logic      [3:0] level
);
  logic [3:0] settled = 4'hf;
  int         bounce[4] = '{0, 0, 0, 0};
  initial level = 4'hf;
  // Chatter lasts five cycles, shorter than a sample period
  always @(posedge clk) begin
    for (int c = 0; c < 4; c++) begin
      if (target[c] != settled[c]) begin
        settled[c] <= target[c];
        bounce[c]  <= 5;
      end else if (bounce[c] > 0) bounce[c] <= bounce[c] - 1;
      // Toggling while bouncing, then the contact state; open reads high
      level[c] <= (bounce[c] > 0) ? ~level[c] : settled[c];
    end
  end
endmodule : switch_model

/* File: tb/tb_top.sv */
// Self-checking bench for the switch debouncer
`timescale 1ns/10ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module tb_top;
  localparam logic [1:0] OK  = debounce_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = debounce_pkg::RESP_SLVERR;
  // Clock, reset and pins
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  target = 4'hf;
  logic [3:0]  switch_input;
  // Register bus
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  // Debounced outputs
  logic [3:0]  debounced_level, rise_pulse, fall_pulse, either_pulse;
  logic        filtered_event_irq, sample_tick_irq;
  int          mismatches = 0;
  int          n_tests = 0;
  int          n_events = 0;
  // Filtered event pulses, counted as the handler would
  always @(posedge clk) begin
    if (filtered_event_irq === 1'b1) n_events++;
  end
  // Short half period keeps a tick every eight cycles
  switch_debouncer #(.HALF_PERIOD(32'h4)) u_switch_debouncer (.clk, .arst_n, .switch_input,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .debounced_level, .rise_pulse, .fall_pulse, .either_pulse,
    .filtered_event_irq, .sample_tick_irq);
  switch_model u_switch_model (.clk, .target, .level(switch_input));
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic time_out();
    mismatches++;
    give_verdict();
  endtask : time_out
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (!s_axi_bvalid) time_out();
    `CHK("bresp", er, s_axi_bresp)
    // One idle edge so a following call never re-drives bready in this step
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    if (!s_axi_rvalid) time_out();
    `CHK("rdata", ed, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
    // One idle edge so a following call never re-drives rready in this step
    @(posedge clk);
  endtask : rd
  task automatic ticks(input int k); // Polling wait between level reads
    int n;
    n = 0;
    while (k > 0 && n < 200) begin
      @(posedge clk);
      n++;
      if (sample_tick_irq) k--;
    end
    if (k > 0) time_out();
  endtask : ticks
  // Reset values, priming tick, unmapped and read-only places
  task automatic t_reset();
    `CHK("level", 4'h0, debounced_level)
    rd(8'h00, 32'h1, OK);
    rd(8'h04, 32'h4, OK);
    ticks(3);
    rd(8'h08, 32'hf, OK);
    rd(8'h0c, 32'h0, OK);
    rd(8'h10, 32'h0, OK);
    rd(8'h14, 32'h0, ERR);
    wr(8'h14, 32'h1, ERR);
    wr(8'h10, 32'hff, OK);
    rd(8'h10, 32'h0, OK);
  endtask : t_reset
  // Press one, then release it while pressing another
  task automatic t_edges();
    target <= 4'he;
    ticks(3);
    rd(8'h08, 32'he, OK);
    rd(8'h0c, 32'h10, OK);
    rd(8'h0c, 32'h0, OK);
    rd(8'h10, 32'h1, OK);
    target <= 4'hb;
    ticks(3);
    rd(8'h0c, 32'h41, OK);
    rd(8'h10, 32'h00010002, OK);
    target <= 4'hf;
    ticks(3);
    rd(8'h0c, 32'h04, OK);
  endtask : t_edges
  // Invert bit flips every channel at the next tick
  task automatic t_invert();
    wr(8'h00, 32'h3, OK);
    rd(8'h00, 32'h3, OK);
    ticks(2);
    rd(8'h0c, 32'hf0, OK);
    rd(8'h10, 32'h01030103, OK);
    wr(8'h00, 32'h1, OK);
    ticks(2);
    rd(8'h0c, 32'h0f, OK);
  endtask : t_invert
  // Disabled sampling ignores the pin until enabled again
  task automatic t_disable();
    int seen;
    seen = 0;
    wr(8'h00, 32'h0, OK);
    target <= 4'hd;
    repeat (40) begin
      @(posedge clk);
      if (sample_tick_irq) seen++;
    end
    `CHK("ticks", 0, seen)
    rd(8'h08, 32'hf, OK);
    wr(8'h00, 32'h1, OK);
    ticks(2);
    rd(8'h0c, 32'h20, OK);
    rd(8'h10, 32'h02040304, OK);
    `CHK("events", 6, n_events)
  endtask : t_disable
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_edges();
    t_invert();
    t_disable();
    give_verdict();
  end
endmodule : tb_top
